// ### verilog/zsc_pkg.sv
// Package of constants for the zero-speed clamp and direction select block.
`default_nettype none

package zsc_pkg;

    // ****************************************************************
    // Clamp function select codes and range.
    // ****************************************************************
    localparam logic [2:0] CLAMP_SEL_LEVEL = 3'h0;
    localparam logic [2:0] CLAMP_SEL_TIMED = 3'h1;
    localparam logic [2:0] CLAMP_SEL_MAX = 3'h4;

    // ****************************************************************
    // Digital input function settings.
    // ****************************************************************
    localparam logic [5:0] FUNC_UNASSIGNED = 6'h00;
    localparam logic [5:0] CLAMP_SET_CLOSED = 6'h15;
    localparam logic [5:0] CLAMP_SET_OPEN = 6'h16;
    localparam logic [5:0] DIR_SET_CLOSED = 6'h19;
    localparam logic [5:0] DIR_SET_OPEN = 6'h14;

    // ****************************************************************
    // Zero speed width in 0.1 rps steps, timer in ms.
    // ****************************************************************
    localparam logic [7:0] ZERO_WIDTH_MIN = 8'h01;
    localparam logic [7:0] ZERO_WIDTH_MAX = 8'h14;
    localparam logic [7:0] ZERO_WIDTH_DEF = 8'h05;
    localparam logic [14:0] TIMER_MAX_MS = 15'h7530;
    localparam logic [14:0] TIMER_DEF_MS = 15'h000a;

    // ****************************************************************
    // Clock rate and the millisecond tick derived from it.
    // ****************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

    // ****************************************************************
    // Lock state machine.
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_LOCK = 2'b01,
        ST_EXIT = 2'b10
    } zsc_state_e;

endpackage : zsc_pkg

`default_nettype wire

// ### verilog/zsc_zero_cmp.sv
// Magnitude compare of a signed speed against the zero speed width.
`timescale 1ns/1ps
`default_nettype none

module zsc_zero_cmp #(
    parameter int SPD_W = 16
) (
    input wire logic signed [SPD_W-1:0] i_speed, // Signed speed.
    input wire logic [7:0] i_width,              // Zero speed width.
    output logic o_is_zero,                      // Magnitude at or below.
    output logic [SPD_W-1:0] o_mag               // Speed magnitude.
);

    // Magnitude, then compare with the width widened to speed size.
    always_comb
    begin
        o_mag = i_speed[SPD_W-1] ? SPD_W'(-i_speed) : SPD_W'(i_speed);
        o_is_zero = (o_mag <= {{(SPD_W-8){1'b0}}, i_width});
    end

endmodule : zsc_zero_cmp
`default_nettype wire

// ### verilog/zsc_clamp_dir.sv
// Zero-speed clamp decision, exit ramp and rotation direction select.
//
// Behaviour
// - Select 0: lock when clamp input valid and command within zero width.
// - Select 0 clamp works only when clamp function is assigned to input.
// - Clamp input setting 21 or 22; active at low level.
// - Select 0: high clamp input level never clamps, even at low command speed.
// - Select 1: ignore input; lock after timed zero command and speed.
// - While locked hold captured position and drive displacement back.
// - Select 1: nonzero command exits lock, ramps at exit acceleration.
// - Zero width 0.1 to 2 rps, default 0.5; at or below is zero.
// - Clamp function select takes 0 to 4, default 0.
// - Speed follows the command; zero command holds zero speed.
// - Assigned run enable input off stops the motor whatever command.
// - Assigned direction switch overrides command sign for direction.
// - Direction switch setting 25 or 20; 0 means command sign rules.
// - No switch: setup 0 positive is clockwise; setup 1 reverses.
// - With switch: setup 0 high level clockwise; setup 1 inverts.
`timescale 1ns/1ps
`default_nettype none

module zsc_clamp_dir #(
    parameter int SPD_W = 16,
    parameter int POS_W = 32,
    parameter int MS_CYCLES = zsc_pkg::MS_CYCLES
) (
    input wire logic i_clk,                          // 20 MHz clock.
    input wire logic i_reset,                        // Async reset, high.
    input wire logic signed [SPD_W-1:0] i_speed_cmd, // Command, 0.1 rps.
    input wire logic signed [SPD_W-1:0] i_actual_speed, // Actual, 0.1 rps.
    input wire logic signed [POS_W-1:0] i_actual_position, // Shaft position.
    input wire logic [7:0] i_zero_speed_width,       // Width, 0.1 rps.
    input wire logic [14:0] i_motion_condition_timer, // Timer in ms.
    input wire logic [2:0] i_clamp_function_select,  // Clamp mode.
    input wire logic [SPD_W-1:0] i_clamp_exit_acceleration, // Per ms.
    input wire logic [5:0] i_clamp_input_setting,    // Clamp input func.
    input wire logic i_clamp_request_input,          // Clamp pin level.
    input wire logic [5:0] i_dir_input_setting,      // Direction func.
    input wire logic i_direction_switch_input,       // Direction pin level.
    input wire logic i_rotation_direction_setup,     // Direction invert.
    input wire logic i_run_enable_assigned,          // Run enable in use.
    input wire logic i_run_enable_input,             // Run enable logic.
    output logic o_position_lock,                    // Position lock active.
    output logic signed [POS_W-1:0] o_lock_position, // Captured position.
    output logic signed [POS_W-1:0] o_position_error, // Hold correction.
    output logic [SPD_W-1:0] o_speed_mag,            // Speed reference.
    output logic o_dir_cw,                           // Clockwise select.
    output logic o_motor_stop                        // Run enable stop.
);
    import zsc_pkg::*;

    localparam int MS_W = $clog2(MS_CYCLES);
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);

    // ****************************************************************
    // Parameter conditioning and speed compares.
    // ****************************************************************
    logic [7:0] width_eff;
    logic [14:0] timer_eff;
    logic [2:0] sel_eff;
    logic cmd_zero_band;
    logic act_zero_band;
    logic [SPD_W-1:0] cmd_mag;
    logic cmd_is_zero;
    logic clamp_assigned;
    logic clamp_valid;
    logic dir_assigned;
    logic zero_cond;

    // Out-of-range settings saturate so the compare stays meaningful.
    always_comb
    begin
        if (i_zero_speed_width < ZERO_WIDTH_MIN)
            width_eff = ZERO_WIDTH_MIN;
        else if (i_zero_speed_width > ZERO_WIDTH_MAX)
            width_eff = ZERO_WIDTH_MAX;
        else
            width_eff = i_zero_speed_width;
        if (i_motion_condition_timer > TIMER_MAX_MS)
            timer_eff = TIMER_MAX_MS;
        else
            timer_eff = i_motion_condition_timer;
        if (i_clamp_function_select > CLAMP_SEL_MAX)
            sel_eff = CLAMP_SEL_MAX;
        else
            sel_eff = i_clamp_function_select;
    end

    zsc_zero_cmp #(.SPD_W(SPD_W)) u_cmd_cmp (
        .i_speed(i_speed_cmd),
        .i_width(width_eff),
        .o_is_zero(cmd_zero_band),
        .o_mag(cmd_mag)
    );

    zsc_zero_cmp #(.SPD_W(SPD_W)) u_act_cmp (
        .i_speed(i_actual_speed),
        .i_width(width_eff),
        .o_is_zero(act_zero_band),
        .o_mag()
    );

    // Input function decode; the clamp pin is active at low level.
    assign clamp_assigned = (i_clamp_input_setting == CLAMP_SET_CLOSED) ||
        (i_clamp_input_setting == CLAMP_SET_OPEN);
    assign clamp_valid = clamp_assigned && !i_clamp_request_input &&
        cmd_zero_band;
    assign dir_assigned = (i_dir_input_setting == DIR_SET_CLOSED) ||
        (i_dir_input_setting == DIR_SET_OPEN);
    assign cmd_is_zero = (cmd_mag == '0);
    assign zero_cond = cmd_is_zero && act_zero_band;

    // ****************************************************************
    // Millisecond tick and zero duration counter.
    // ****************************************************************
    logic [MS_W-1:0] ms_cnt_r;
    logic [MS_W-1:0] ms_cnt_nxt;
    logic ms_tick;
    logic [14:0] zero_ms_r;
    logic [14:0] zero_ms_nxt;

    // Free running tick; the duration count restarts on any break.
    always_comb
    begin
        ms_tick = (ms_cnt_r == MS_LAST);
        ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + 1'b1;
        if (!zero_cond)
            zero_ms_nxt = '0;
        else if (ms_tick && zero_ms_r != TIMER_MAX_MS)
            zero_ms_nxt = zero_ms_r + 1'b1;
        else
            zero_ms_nxt = zero_ms_r;
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ms_cnt_r <= '0;
            zero_ms_r <= '0;
        end
        else
        begin
            ms_cnt_r <= ms_cnt_nxt;
            zero_ms_r <= zero_ms_nxt;
        end
    end

    // ****************************************************************
    // Lock state machine, hold position and speed reference.
    // ****************************************************************
    zsc_state_e state_r;
    zsc_state_e state_nxt;
    logic lock_r;
    logic lock_nxt;
    logic signed [POS_W-1:0] lock_pos_r;
    logic signed [POS_W-1:0] lock_pos_nxt;
    logic signed [POS_W-1:0] pos_err_r;
    logic signed [POS_W-1:0] pos_err_nxt;
    logic [SPD_W-1:0] speed_mag_r;
    logic [SPD_W-1:0] speed_mag_nxt;
    logic dir_cw_r;
    logic dir_cw_nxt;
    logic stop_r;
    logic stop_nxt;
    logic [SPD_W:0] ramp_sum;
    logic enter_lock;
    logic run_off;

    // Lock entry per mode, exit ramp and direction choice.
    always_comb
    begin
        run_off = i_run_enable_assigned && !i_run_enable_input;
        ramp_sum = {1'b0, speed_mag_r} + {1'b0, i_clamp_exit_acceleration};
        enter_lock = 1'b0;
        if (sel_eff == CLAMP_SEL_LEVEL)
            enter_lock = clamp_valid;
        else if (sel_eff == CLAMP_SEL_TIMED)
            enter_lock = zero_cond && (zero_ms_r >= timer_eff);
        state_nxt = state_r;
        lock_pos_nxt = lock_pos_r;
        speed_mag_nxt = cmd_mag;
        case (state_r)
            ST_RUN:
            begin
                if (enter_lock)
                begin
                    state_nxt = ST_LOCK;
                    lock_pos_nxt = i_actual_position;
                end
            end
            ST_LOCK:
            begin
                speed_mag_nxt = '0;
                if (sel_eff == CLAMP_SEL_TIMED)
                begin
                    if (!cmd_is_zero)
                        state_nxt = ST_EXIT;
                end
                else if (!enter_lock)
                    state_nxt = ST_RUN;
            end
            ST_EXIT:
            begin
                speed_mag_nxt = speed_mag_r;
                if (ms_tick)
                begin
                    if (ramp_sum >= {1'b0, cmd_mag})
                    begin
                        speed_mag_nxt = cmd_mag;
                        state_nxt = ST_RUN;
                    end
                    else
                        speed_mag_nxt = ramp_sum[SPD_W-1:0];
                end
                if (cmd_is_zero)
                    state_nxt = ST_RUN;
                // A clamp that becomes valid mid-ramp locks at once.
                if (enter_lock)
                begin
                    state_nxt = ST_LOCK;
                    lock_pos_nxt = i_actual_position;
                end
            end
            default:
                state_nxt = ST_RUN;
        endcase
        lock_nxt = (state_nxt == ST_LOCK);
        pos_err_nxt = lock_nxt ? POS_W'(lock_pos_nxt - i_actual_position)
            : '0;
        stop_nxt = run_off;
        if (run_off)
            speed_mag_nxt = '0;
        if (dir_assigned)
            dir_cw_nxt = i_direction_switch_input ^
                i_rotation_direction_setup;
        else
            dir_cw_nxt = !i_speed_cmd[SPD_W-1] ^
                i_rotation_direction_setup;
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_r <= ST_RUN;
            lock_r <= 1'b0;
            lock_pos_r <= '0;
            pos_err_r <= '0;
            speed_mag_r <= '0;
            dir_cw_r <= 1'b1;
            stop_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            lock_r <= lock_nxt;
            lock_pos_r <= lock_pos_nxt;
            pos_err_r <= pos_err_nxt;
            speed_mag_r <= speed_mag_nxt;
            dir_cw_r <= dir_cw_nxt;
            stop_r <= stop_nxt;
        end
    end

    // Outputs come straight from their flip-flops.
    assign o_position_lock = lock_r;
    assign o_lock_position = lock_pos_r;
    assign o_position_error = pos_err_r;
    assign o_speed_mag = speed_mag_r;
    assign o_dir_cw = dir_cw_r;
    assign o_motor_stop = stop_r;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_locked_then_cmd;
        lock_r && sel_eff == CLAMP_SEL_TIMED ##0 !cmd_is_zero;
    endsequence

    sequence s_unlock_ramp;
        !lock_r && state_r == ST_EXIT;
    endsequence

    level_clamp_a: assert property (
        sel_eff == CLAMP_SEL_LEVEL && clamp_valid |=> lock_r)
        else $error("Level clamp did not lock.");
    high_level_a: assert property (
        sel_eff == CLAMP_SEL_LEVEL && i_clamp_request_input |=> !lock_r)
        else $error("High clamp input locked.");
    timed_entry_a: assert property (
        state_r == ST_RUN && sel_eff == CLAMP_SEL_TIMED && zero_cond &&
        zero_ms_r >= timer_eff |=> lock_r && lock_pos_r ==
        $past(i_actual_position))
        else $error("Timed clamp did not lock.");
    timed_exit_a: assert property (
        s_locked_then_cmd |=> s_unlock_ramp)
        else $error("Lock not left on nonzero command.");
    hold_error_a: assert property (
        lock_r && $stable(lock_pos_r) |-> pos_err_r ==
        POS_W'(lock_pos_r - $past(i_actual_position)))
        else $error("Hold correction wrong.");
    reserved_sel_a: assert property (
        sel_eff > CLAMP_SEL_TIMED |=> !lock_r)
        else $error("Reserved select locked.");
    restart_a: assert property (
        !zero_cond |=> zero_ms_r == '0)
        else $error("Zero duration not restarted.");
    run_stop_a: assert property (
        run_off |=> stop_r && speed_mag_r == '0)
        else $error("Run enable off did not stop.");
    dir_sign_a: assert property (
        !dir_assigned |=> dir_cw_r == ($past(!i_speed_cmd[SPD_W-1]) ^
        $past(i_rotation_direction_setup)))
        else $error("Direction from sign wrong.");
    dir_switch_a: assert property (
        dir_assigned |=> dir_cw_r == ($past(i_direction_switch_input) ^
        $past(i_rotation_direction_setup)))
        else $error("Direction from switch wrong.");

endmodule : zsc_clamp_dir
`default_nettype wire

// ### sim/zsc_src_model.sv
// Model of the speed command source and the digital input switches.
`timescale 1ns/1ps
`default_nettype none

module zsc_src_model (
    input wire logic i_clk,                 // Clock.
    input wire logic signed [15:0] i_cmd,   // Requested command.
    input wire logic signed [15:0] i_spd,   // Requested measured speed.
    input wire logic signed [31:0] i_pos,   // Requested shaft position.
    input wire logic [2:0] i_pins,          // Run, direction, clamp levels.
    output logic signed [15:0] o_speed_cmd, // Command to the block.
    output logic signed [15:0] o_actual_speed, // Speed feedback.
    output logic signed [31:0] o_actual_position, // Position feedback.
    output logic [2:0] o_pins               // Switch levels at the pins.
);
    // ****************************************************************
    // Source and switches
    // ****************************************************************
    // The pins start at rest so that the block never sees unknowns.
    initial
    begin
        o_speed_cmd = 16'sh0;
        o_actual_speed = 16'sh0;
        o_actual_position = 32'sh0;
        o_pins = 3'h7;
    end

    // A request reaches the pins just after the next edge, as a switch.
    always @(posedge i_clk)
    begin
        o_speed_cmd <= #2 i_cmd;
        o_actual_speed <= #2 i_spd;
        o_actual_position <= #2 i_pos;
        o_pins <= #2 i_pins;
    end
endmodule : zsc_src_model

`default_nettype wire

// ### sim/zsc_clamp_dir_tb.sv
// Self-checking bench for the zero-speed clamp and direction select.
`timescale 1ns/1ps
`default_nettype none

module zsc_clamp_dir_tb;
    import zsc_pkg::*;

    // ****************************************************************
    // Stimulus, results and counters
    // ****************************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic signed [15:0] cmd = 16'sh0;
    logic signed [15:0] spd = 16'sh0;
    logic signed [31:0] pos = 32'sh3e8;
    logic [2:0] pins = 3'h7;
    logic [7:0] width = ZERO_WIDTH_DEF;
    // Two ticks: one zero stretch alone stays short of it, two would not.
    logic [14:0] tmr = 15'h0002;
    logic [2:0] sel = CLAMP_SEL_LEVEL;
    logic [15:0] accel = 16'h000a;
    logic [5:0] cset = CLAMP_SET_CLOSED;
    logic [5:0] dset = FUNC_UNASSIGNED;
    logic setup = 1'b0;
    logic run_as = 1'b0;
    logic signed [15:0] m_cmd;
    logic signed [15:0] m_spd;
    logic signed [31:0] m_pos;
    logic [2:0] m_pins;
    logic lock;
    logic signed [31:0] lpos;
    logic signed [31:0] perr;
    logic [15:0] smag;
    logic cw;
    logic stop;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    // Level-mode table: command, pins, clamp setting, lock expected.
    localparam logic signed [15:0] C0 [7] = '{3, 5, 6, -5, 0, 0, 0};
    localparam logic [2:0] P0 [7] = '{6, 6, 6, 6, 7, 6, 6};
    localparam logic [5:0] S0 [7] = '{21, 21, 21, 21, 21, 22, 0};
    localparam logic E0 [7] = '{1, 1, 0, 1, 0, 1, 0};

    // ****************************************************************
    // Instances and clock
    // ****************************************************************
    zsc_src_model i_zsc_src_model (.i_clk(clk), .i_cmd(cmd), .i_spd(spd),
        .i_pos(pos), .i_pins(pins), .o_speed_cmd(m_cmd),
        .o_actual_speed(m_spd), .o_actual_position(m_pos), .o_pins(m_pins));

    zsc_clamp_dir #(.MS_CYCLES(10)) i_zsc_clamp_dir (.i_clk(clk),
        .i_reset(rst), .i_speed_cmd(m_cmd), .i_actual_speed(m_spd),
        .i_actual_position(m_pos), .i_zero_speed_width(width),
        .i_motion_condition_timer(tmr), .i_clamp_function_select(sel),
        .i_clamp_exit_acceleration(accel), .i_clamp_input_setting(cset),
        .i_clamp_request_input(m_pins[0]), .i_dir_input_setting(dset),
        .i_direction_switch_input(m_pins[1]),
        .i_rotation_direction_setup(setup),
        .i_run_enable_assigned(run_as), .i_run_enable_input(m_pins[2]),
        .o_position_lock(lock), .o_lock_position(lpos),
        .o_position_error(perr), .o_speed_mag(smag), .o_dir_cw(cw),
        .o_motor_stop(stop));

    // The clock toggles every 25 ns, a full period of 50 ns.
    always #25 clk = ~clk;

    // A hang is cut short well beyond the few hundred cycles needed.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            close_out();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Waits for edges, then steps just past the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    // Compares a single flag.
    task automatic chk_bit(input string what, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %0b seen %0b", what, e, g);
        end
    endtask : chk_bit

    // Compares a word value.
    task automatic chk_word(input string what, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk_word

    // Waits a bounded time for the lock flag to take a value.
    task automatic wait_lock(input logic v, input int lim);
        for (int k = 0; k < lim && lock !== v; k++)
            tick(1);
    endtask : wait_lock

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        tick(10);
        chk_bit("reset lock", 1'b0, lock);
        chk_bit("reset cw", 1'b1, cw);
        chk_word("reset speed", 32'h0, {16'h0, smag});
        rst = 1'b0;
        tick(2);
        for (int i = 0; i < 7; i++)
        begin
            cmd = C0[i];
            pins = P0[i];
            cset = S0[i];
            tick(2);
            chk_bit("level lock", E0[i], lock);
        end
        $display("Test level clamp done");
        cset = CLAMP_SET_CLOSED;
        cmd = 16'sh3;
        tick(2);
        pos = 32'sh3ef;
        tick(3);
        chk_word("lock position", 32'h3e8, lpos);
        chk_word("hold error", 32'hfffffff9, perr);
        chk_word("locked speed", 32'h0, {16'h0, smag});
        $display("Test hold done");
        pins = 3'h7;
        cmd = 16'sh0;
        spd = 16'sh8;
        sel = CLAMP_SEL_TIMED;
        tick(3);
        spd = 16'sh2;
        tick(14);
        chk_bit("early lock", 1'b0, lock);
        spd = 16'sh8;
        tick(2);
        spd = 16'sh2;
        tick(14);
        chk_bit("restart lock", 1'b0, lock);
        wait_lock(1'b1, 40);
        chk_bit("timed lock", 1'b1, lock);
        cmd = 16'sh32;
        tick(2);
        chk_bit("exit lock", 1'b0, lock);
        chk_word("exit start", 32'h0, {16'h0, smag});
        tick(20);
        chk_bit("ramping", 1'b1, smag < 16'h32);
        for (int k = 0; k < 80 && smag !== 16'h32; k++)
            tick(1);
        chk_word("ramp end", 32'h32, {16'h0, smag});
        $display("Test timed clamp done");
        cmd = 16'sh0;
        spd = 16'sh0;
        pins = 3'h6;
        for (int s = 2; s < 5; s++)
        begin
            sel = s[2:0];
            tick(40);
            chk_bit("reserved lock", 1'b0, lock);
        end
        $display("Test reserved select done");
        pins = 3'h7;
        cmd = -16'sd30;
        tick(2);
        sel = CLAMP_SEL_LEVEL;
        tick(2);
        chk_word("follow speed", 32'h1e, {16'h0, smag});
        run_as = 1'b1;
        pins = 3'h3;
        tick(2);
        chk_bit("stop on", 1'b1, stop);
        chk_word("stop speed", 32'h0, {16'h0, smag});
        run_as = 1'b0;
        tick(2);
        chk_bit("stop unused", 1'b0, stop);
        cmd = 16'sh0;
        tick(2);
        chk_word("zero speed", 32'h0, {16'h0, smag});
        $display("Test run enable done");
        for (int i = 0; i < 24; i++)
        begin
            setup = i[0];
            pins = {1'b1, i[1], 1'b1};
            cmd = i[2] ? -16'sd9 : 16'sd9;
            dset = (i < 8) ? FUNC_UNASSIGNED :
                (i < 16) ? DIR_SET_CLOSED : DIR_SET_OPEN;
            tick(2);
            chk_bit("direction", ((i < 8) ? ~i[2] : i[1]) ^ i[0], cw);
        end
        $display("Test direction done");
        close_out();
    end
endmodule : zsc_clamp_dir_tb

`default_nettype wire
